//--- hw/hcs_pkg.sv
// Shared constants and types for the hub status and command block
package hcs_pkg;

	localparam int         HCS_ADDR_W          = 8;
	localparam int         HCS_DATA_W          = 8;
	localparam int         HCS_NUM_PORTS       = 4;

	// Register offsets
	localparam logic [7:0] HCS_OFS_STATUS_CMD  = 8'hf8;
	localparam logic [7:0] HCS_OFS_FEATURE_CFG = 8'hf0;

	// Status and command field layout
	localparam int         HCS_BIT_CFG_ACTIVE  = 0;
	localparam int         HCS_BIT_SOFT_RST    = 1;
	localparam int         HCS_RSVD_LSB        = 2;
	localparam int         HCS_RSVD_MSB        = 7;
	localparam logic [7:0] HCS_STATUS_RESET    = 8'h00;

	// Feature configuration register, bits above the field read as zero
	localparam int         HCS_FEATURE_W       = 5;
	localparam logic [4:0] HCS_FEATURE_RESET   = 5'h00;

	// Timing counts in clock cycles
	localparam int         HCS_RELOAD_CYCLES   = 4;
	localparam int         HCS_STRAP_SETTLE    = 8;

	typedef enum logic {
		HCS_RST_IDLE,
		HCS_RST_RELOAD
	} hcs_rst_state_e;

endpackage

//--- hw/hcs_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module hcs_sync3
	import hcs_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Pins in, clean level out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] mid_reg;
	logic [W-1:0] late_reg;
	logic [W-1:0] dout_reg;
	logic [W-1:0] differ;

	// Stage one feeds stage two only, so a metastable value never fans out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			mid_reg  <= '0;
			late_reg <= '0;
		end else begin
			meta_reg <= din;
			mid_reg  <= meta_reg;
			late_reg <= mid_reg;
		end
	end

	assign differ = mid_reg ^ late_reg;

	// Each bit holds while its last two stages disagree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_reg <= '0;
		end else begin
			dout_reg <= (~differ & late_reg) | (differ & dout_reg);
		end
	end

	assign dout = dout_reg;

endmodule // hcs_sync3

//--- hw/hcs_port_power.sv
// Power switch enable and charge enable for one downstream port
`timescale 1ns/1ps
module hcs_port_power
	import hcs_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Latched strap decisions
	input  wire logic strap_valid,
	input  wire logic full_pm,
	input  wire logic individual,
	input  wire logic active_high,
	input  wire logic charge_strap,
	// Power requests from the hub
	input  wire logic req,
	input  wire logic any_req,
	// Port controls
	output logic      switch_out,
	output logic      charge_out
);

	logic en;
	logic switch_reg;
	logic charge_reg;

	always_comb begin
		en = 1'h0;
		if (strap_valid) begin
			if (!full_pm) begin
				// Without power management the port is simply kept powered
				en = 1'h1;
			end else if (individual) begin
				en = req; // R11
			end else begin
				en = any_req; // R12
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			switch_reg <= 1'h0;
		end else begin
			switch_reg <= active_high ? en : !en; // R10
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_reg <= 1'h0;
		end else begin
			charge_reg <= strap_valid && charge_strap; // R09
		end
	end

	assign switch_out = switch_reg;
	assign charge_out = charge_reg;

	default clocking cb_port @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_charge;
		strap_valid && charge_strap |=> charge_out;
	endproperty
	a_charge: assert property (p_charge) else $error("charge enable missing"); // R09

	property p_individual;
		strap_valid && full_pm && individual
			|=> switch_out == (active_high ? $past(req) : !$past(req));
	endproperty
	a_individual: assert property (p_individual) else $error("port switch wrong"); // R11

	property p_polarity;
		strap_valid && !full_pm && active_high |=> switch_out;
	endproperty
	a_polarity: assert property (p_polarity) else $error("active high switch off"); // R10

endmodule // hcs_port_power

//--- hw/hcs_status_command.sv
// Hub status and command register, soft reset sequencer and strap decode
`timescale 1ns/1ps
// Behaviour
// (R01) Bits seven to two of the status and command register read zero and ignore writes.
// (R02) Writing one to the soft reset bit reloads every configuration register to its reset value.
// (R03) The soft reset bit sets only on a written one, a written zero does nothing.
// (R04) Hardware clears the soft reset bit once the reload has completed.
// (R05) Entering serial configuration mode sets the configuration active flag in bit zero.
// (R06) The upstream port stays disconnected while the configuration active flag is one.
// (R07) The serial host clears the configuration active flag to end configuration mode.
// (R08) The flag clears only on a written one to bit zero, a written zero leaves it alone.
// (R09) A high charge enable strap turns on battery charging support for its port.
// (R10) A high or unconnected polarity strap makes the power switch enables active high.
// (R11) With the shared power and power management straps low, each port is powered on its own.
// (R12) A low power management strap gives full power management of the downstream ports.
// (R13) The soft reset bit reads one while a triggered reload is still running.
module hcs_status_command
	import hcs_pkg::*;
#(
	parameter int RELOAD_CYCLES = HCS_RELOAD_CYCLES,
	parameter int NUM_PORTS     = HCS_NUM_PORTS
) (
	// Clock and global reset
	input  wire logic                  CLK,
	input  wire logic                  RESETN,
	// Register access from the serial interface
	input  wire logic [HCS_ADDR_W-1:0] REG_ADDR,
	input  wire logic [HCS_DATA_W-1:0] REG_WDATA,
	input  wire logic                  REG_WR,
	input  wire logic                  REG_RD,
	output logic      [HCS_DATA_W-1:0] REG_RDATA,
	output logic                       REG_RVALID,
	// Serial configuration mode entry
	input  wire logic                  CFG_MODE_ENTER,
	// Strap pins
	input  wire logic [NUM_PORTS-1:0]  CHARGE_ENABLE_STRAP_PORT,
	input  wire logic                  POWER_SWITCH_POLARITY_STRAP,
	input  wire logic                  SHARED_POWER_STRAP,
	input  wire logic                  FULL_POWER_MGMT_STRAP_N,
	// Hub power requests
	input  wire logic [NUM_PORTS-1:0]  PORT_POWER_REQ,
	// Port and hub controls
	output logic      [NUM_PORTS-1:0]  PORT_POWER_SWITCH_OUT,
	output logic      [NUM_PORTS-1:0]  CHARGE_ENABLE_OUT,
	output logic                       FULL_POWER_MGMT,
	output logic                       INDIVIDUAL_POWER,
	output logic                       UPSTREAM_CONNECT_EN,
	output logic [HCS_FEATURE_W-1:0]   FEATURE_CFG
);

	localparam int STRAP_W  = NUM_PORTS + 3;
	localparam int CNT_W    = $clog2(RELOAD_CYCLES + 1);
	localparam int SCNT_W   = $clog2(HCS_STRAP_SETTLE + 1);
	localparam int POL_IDX  = NUM_PORTS;
	localparam int SHR_IDX  = NUM_PORTS + 1;
	localparam int FPM_IDX  = NUM_PORTS + 2;

	localparam logic [CNT_W-1:0]  RELOAD_LAST = CNT_W'(RELOAD_CYCLES - 1);
	localparam logic [SCNT_W-1:0] SETTLE_LAST = SCNT_W'(HCS_STRAP_SETTLE - 1);

	hcs_rst_state_e            rst_state_reg;
	logic [CNT_W-1:0]          reload_cnt_reg;
	logic                      reload_last;
	logic                      soft_reset_reg;
	logic                      soft_trig;
	logic                      wr_status;
	logic                      wr_feature;
	logic                      config_in_progress_reg;
	logic                      config_in_progress_next;
	logic                      upstream_reg;
	logic [HCS_FEATURE_W-1:0]  feature_cfg_reg;
	logic [HCS_DATA_W-1:0]     rdata_reg;
	logic [HCS_DATA_W-1:0]     rdata_next;
	logic [HCS_DATA_W-1:0]     status_word;
	logic                      rvalid_reg;
	logic                      rd_status_reg;
	logic [STRAP_W-1:0]        strap_sync;
	logic [SCNT_W-1:0]         strap_cnt_reg;
	logic                      strap_done_reg;
	logic [NUM_PORTS-1:0]      charge_strap_reg;
	logic                      active_high_reg;
	logic                      full_pm_reg;
	logic                      individual_reg;
	logic                      any_req;

	// Register decode
	assign wr_status   = REG_WR && (REG_ADDR == HCS_OFS_STATUS_CMD);
	assign wr_feature  = REG_WR && (REG_ADDR == HCS_OFS_FEATURE_CFG);
	assign reload_last = (rst_state_reg == HCS_RST_RELOAD) && (reload_cnt_reg == RELOAD_LAST);

	// A second soft reset request during a reload is absorbed by the one in flight
	assign soft_trig = wr_status && REG_WDATA[HCS_BIT_SOFT_RST]
		&& (rst_state_reg == HCS_RST_IDLE); // R03

	// Soft reset sequencer
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_state_reg  <= HCS_RST_IDLE;
			reload_cnt_reg <= '0;
		end else begin
			case (rst_state_reg)
				HCS_RST_IDLE: begin
					if (soft_trig) begin
						rst_state_reg  <= HCS_RST_RELOAD; // R02
						reload_cnt_reg <= '0;
					end
				end
				HCS_RST_RELOAD: begin
					if (reload_last) begin
						rst_state_reg <= HCS_RST_IDLE;
					end else begin
						reload_cnt_reg <= reload_cnt_reg + 1'h1;
					end
				end
				default: begin
					rst_state_reg  <= HCS_RST_IDLE;
					reload_cnt_reg <= '0;
				end
			endcase
		end
	end

	// Soft reset bit, visible for the whole reload
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			soft_reset_reg <= HCS_STATUS_RESET[HCS_BIT_SOFT_RST];
		end else if (soft_trig) begin
			soft_reset_reg <= 1'h1; // R03
		end else if (reload_last) begin
			soft_reset_reg <= 1'h0; // R04
		end
	end

	// Configuration register, forced to its reset value through the reload
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			feature_cfg_reg <= HCS_FEATURE_RESET;
		end else if (soft_trig || (rst_state_reg == HCS_RST_RELOAD)) begin
			feature_cfg_reg <= HCS_FEATURE_RESET; // R02
		end else if (wr_feature) begin
			feature_cfg_reg <= REG_WDATA[HCS_FEATURE_W-1:0];
		end
	end

	// Configuration active flag, a new entry wins over a clear in the same cycle
	always_comb begin
		config_in_progress_next = config_in_progress_reg;
		if (CFG_MODE_ENTER) begin
			config_in_progress_next = 1'h1; // R05
		end else if (wr_status && REG_WDATA[HCS_BIT_CFG_ACTIVE]) begin
			config_in_progress_next = 1'h0; // R08
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			config_in_progress_reg <= HCS_STATUS_RESET[HCS_BIT_CFG_ACTIVE];
		end else begin
			config_in_progress_reg <= config_in_progress_next;
		end
	end

	// Built from the next flag value so the connect enable never lags the flag
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			upstream_reg <= 1'h0;
		end else begin
			upstream_reg <= !config_in_progress_next && strap_done_reg; // R06
		end
	end

	// Read data
	always_comb begin
		status_word                     = HCS_STATUS_RESET; // R01
		status_word[HCS_BIT_SOFT_RST]   = soft_reset_reg; // R13
		status_word[HCS_BIT_CFG_ACTIVE] = config_in_progress_reg;
		case (REG_ADDR)
			HCS_OFS_STATUS_CMD:  rdata_next = status_word;
			HCS_OFS_FEATURE_CFG: rdata_next = HCS_DATA_W'(feature_cfg_reg);
			default:             rdata_next = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_reg     <= '0;
			rvalid_reg    <= 1'h0;
			rd_status_reg <= 1'h0;
		end else begin
			rvalid_reg    <= REG_RD;
			rd_status_reg <= REG_RD && (REG_ADDR == HCS_OFS_STATUS_CMD);
			if (REG_RD) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// Strap pins enter through the synchroniser
	hcs_sync3 #(
		.W (STRAP_W)
	) u_strap_sync (
		.clk   (CLK),
		.rst_n (RESETN),
		.din   ({FULL_POWER_MGMT_STRAP_N, SHARED_POWER_STRAP,
			POWER_SWITCH_POLARITY_STRAP, CHARGE_ENABLE_STRAP_PORT}),
		.dout  (strap_sync)
	);

	// Straps are caught once after reset; later pin changes are not followed
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			strap_cnt_reg  <= '0;
			strap_done_reg <= 1'h0;
		end else if (!strap_done_reg) begin
			if (strap_cnt_reg == SETTLE_LAST) begin
				strap_done_reg <= 1'h1;
			end else begin
				strap_cnt_reg <= strap_cnt_reg + 1'h1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			charge_strap_reg <= '0;
			active_high_reg  <= 1'h1;
			full_pm_reg      <= 1'h0;
			individual_reg   <= 1'h0;
		end else if (!strap_done_reg && (strap_cnt_reg == SETTLE_LAST)) begin
			charge_strap_reg <= strap_sync[NUM_PORTS-1:0]; // R09
			active_high_reg  <= strap_sync[POL_IDX]; // R10
			full_pm_reg      <= !strap_sync[FPM_IDX]; // R12
			individual_reg   <= !strap_sync[SHR_IDX] && !strap_sync[FPM_IDX]; // R11
		end
	end

	assign any_req = |PORT_POWER_REQ;

	// Per-port power and charge control
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		hcs_port_power u_port (
			.clk          (CLK),
			.rst_n        (RESETN),
			.strap_valid  (strap_done_reg),
			.full_pm      (full_pm_reg),
			.individual   (individual_reg),
			.active_high  (active_high_reg),
			.charge_strap (charge_strap_reg[i]),
			.req          (PORT_POWER_REQ[i]),
			.any_req      (any_req),
			.switch_out   (PORT_POWER_SWITCH_OUT[i]),
			.charge_out   (CHARGE_ENABLE_OUT[i])
		);
	end

	assign REG_RDATA           = rdata_reg;
	assign REG_RVALID          = rvalid_reg;
	assign UPSTREAM_CONNECT_EN = upstream_reg;
	assign FEATURE_CFG         = feature_cfg_reg;
	assign FULL_POWER_MGMT     = full_pm_reg;
	assign INDIVIDUAL_POWER    = individual_reg;

	default clocking cb_main @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_soft_trig;
		soft_trig;
	endsequence

	sequence s_reload_window;
		soft_reset_reg [*4] ##1 !soft_reset_reg;
	endsequence

	property p_rsvd_zero;
		REG_RVALID && rd_status_reg |-> REG_RDATA[HCS_RSVD_MSB:HCS_RSVD_LSB] == '0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero"); // R01

	property p_soft_hold;
		s_soft_trig |=> s_reload_window;
	endproperty
	a_soft_hold: assert property (p_soft_hold) else $error("soft reset length wrong"); // R03

	property p_soft_done;
		$fell(soft_reset_reg) |-> rst_state_reg == HCS_RST_IDLE
			&& FEATURE_CFG == HCS_FEATURE_RESET;
	endproperty
	a_soft_done: assert property (p_soft_done) else $error("reload incomplete"); // R04

	property p_reload_value;
		rst_state_reg == HCS_RST_RELOAD |-> FEATURE_CFG == HCS_FEATURE_RESET;
	endproperty
	a_reload_value: assert property (p_reload_value) else $error("config not reloaded"); // R02

	property p_soft_zero;
		wr_status && !REG_WDATA[HCS_BIT_SOFT_RST] && !soft_reset_reg |=> !soft_reset_reg;
	endproperty
	a_soft_zero: assert property (p_soft_zero) else $error("zero write set reset"); // R03

	property p_busy_read;
		REG_RD && REG_ADDR == HCS_OFS_STATUS_CMD && rst_state_reg == HCS_RST_RELOAD
			|=> REG_RVALID && REG_RDATA[HCS_BIT_SOFT_RST];
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy read shows zero"); // R13

	property p_cfg_set;
		CFG_MODE_ENTER |=> config_in_progress_reg && !UPSTREAM_CONNECT_EN;
	endproperty
	a_cfg_set: assert property (p_cfg_set) else $error("config flag not set"); // R05

	property p_upstream_hold;
		config_in_progress_reg |-> !UPSTREAM_CONNECT_EN;
	endproperty
	a_upstream_hold: assert property (p_upstream_hold) else $error("upstream connected"); // R06

	property p_cfg_keep;
		wr_status && !REG_WDATA[HCS_BIT_CFG_ACTIVE] && config_in_progress_reg
			|=> config_in_progress_reg;
	endproperty
	a_cfg_keep: assert property (p_cfg_keep) else $error("zero write cleared flag"); // R08

	property p_cfg_clear;
		wr_status && REG_WDATA[HCS_BIT_CFG_ACTIVE] && !CFG_MODE_ENTER
			|=> !config_in_progress_reg;
	endproperty
	a_cfg_clear: assert property (p_cfg_clear) else $error("flag not cleared"); // R07

endmodule // hcs_status_command

//--- verification/hcs_host_model.sv
// Serial host model that drives the register port and configuration mode entry
`timescale 1ns/1ps
module hcs_host_model
	import hcs_pkg::*;
(
	// Clock
	input  wire logic                  clk,
	// Register requests
	output logic      [HCS_ADDR_W-1:0] reg_addr,
	output logic      [HCS_DATA_W-1:0] reg_wdata,
	output logic                       reg_wr,
	output logic                       reg_rd,
	// Configuration mode entry
	output logic                       cfg_enter
);
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		cfg_enter = 1'b0;
	end

	// Idle bus carries inverted values so a stale address or byte is never mistaken for live
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic read(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
	endtask

	task automatic enter_cfg;
		@(posedge clk);
		cfg_enter <= 1'b1;
		@(posedge clk);
		cfg_enter <= 1'b0;
	endtask

	// Ending configuration is a written one on bit zero, never a zero
	task automatic clear_cfg;
		write(HCS_OFS_STATUS_CMD, 8'h01);
	endtask
endmodule // hcs_host_model

//--- verification/hcs_status_command_tb.sv
// Self-checking testbench for the hub status and command block
`timescale 1ns/1ps
module hcs_status_command_tb
	import hcs_pkg::*;
;
	logic       clk;
	logic       resetn;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd_s;
	logic [7:0] rdata;
	logic       rvalid;
	logic       cfg_enter;
	logic [3:0] chg_strap;
	logic       pol_strap;
	logic       shared_strap;
	logic       fpm_strap_n;
	logic [3:0] req;
	logic [3:0] sw_out;
	logic [3:0] chg_out;
	logic       fpm;
	logic       indiv;
	logic       up_en;
	logic [4:0] feat;
	logic [7:0] exp_q[$];
	logic [3:0] en;
	logic [7:0] d;
	logic       full;
	logic       ind;
	int         failures;
	int         comparisons;
	int         seed;

	hcs_status_command hcs_status_command_i (
		.CLK(clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd_s), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CFG_MODE_ENTER(cfg_enter),
		.CHARGE_ENABLE_STRAP_PORT(chg_strap), .POWER_SWITCH_POLARITY_STRAP(pol_strap),
		.SHARED_POWER_STRAP(shared_strap), .FULL_POWER_MGMT_STRAP_N(fpm_strap_n),
		.PORT_POWER_REQ(req), .PORT_POWER_SWITCH_OUT(sw_out), .CHARGE_ENABLE_OUT(chg_out),
		.FULL_POWER_MGMT(fpm), .INDIVIDUAL_POWER(indiv), .UPSTREAM_CONNECT_EN(up_en),
		.FEATURE_CFG(feat)
	);

	hcs_host_model hcs_host_model_i (
		.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd_s),
		.cfg_enter(cfg_enter)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		hcs_host_model_i.read(a);
	endtask

	// Let the edge's updates land before looking at levels
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Read data is judged against the oldest note whenever a result appears
	always @(posedge clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("MISMATCH t=%0t read result with nothing expected", $time);
			end else
				chk(rdata, exp_q.pop_front(), "read data");
		end
	end

	initial begin
		#20000;
		failures++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		failures = 0;
		comparisons = 0;
		seed = 67650;
		resetn = 1'b0;
		req = 4'h0;
		chg_strap = 4'h0;
		pol_strap = 1'b1;
		shared_strap = 1'b0;
		fpm_strap_n = 1'b0;
		// Straps only latch after reset, so each strap mix needs its own reset
		for (int cfg = 0; cfg < 3; cfg++) begin
			@(posedge clk);
			resetn <= 1'b0;
			chg_strap <= 4'($random(seed));
			pol_strap <= (cfg != 1);
			shared_strap <= (cfg == 1);
			fpm_strap_n <= (cfg == 2);
			repeat (5) @(posedge clk);
			resetn <= 1'b1;
			settle(12);
			full = !fpm_strap_n;
			ind = !shared_strap && full;
			chk({7'h0, fpm}, {7'h0, full}, "full power mgmt");
			chk({7'h0, indiv}, {7'h0, ind}, "individual power");
			chk({4'h0, chg_out}, {4'h0, chg_strap}, "charge enable");
			chk({7'h0, up_en}, 8'h01, "upstream after reset");
			rd(HCS_OFS_STATUS_CMD, HCS_STATUS_RESET);
			repeat (4) begin
				@(posedge clk);
				req <= 4'($random(seed));
				settle(2);
				en = !full ? 4'hf : ind ? req : {4{|req}};
				chk({4'h0, sw_out}, {4'h0, pol_strap ? en : ~en}, "switch");
			end
			hcs_host_model_i.enter_cfg();
			settle(1);
			chk({7'h0, up_en}, 8'h00, "upstream held");
			rd(HCS_OFS_STATUS_CMD, 8'h01);
			hcs_host_model_i.write(HCS_OFS_STATUS_CMD, 8'hfc);
			rd(HCS_OFS_STATUS_CMD, 8'h01);
			hcs_host_model_i.clear_cfg();
			settle(1);
			chk({7'h0, up_en}, 8'h01, "upstream released");
			rd(HCS_OFS_STATUS_CMD, 8'h00);
			// Entry and clear in one cycle: entry must win
			fork
				hcs_host_model_i.enter_cfg();
				hcs_host_model_i.clear_cfg();
			join
			rd(HCS_OFS_STATUS_CMD, 8'h01);
			hcs_host_model_i.clear_cfg();
			// Low bit forced so the reload below has something to undo
			d = 8'($random(seed)) | 8'h01;
			hcs_host_model_i.write(HCS_OFS_FEATURE_CFG, d);
			rd(HCS_OFS_FEATURE_CFG, {3'h0, d[4:0]});
			chk({3'h0, feat}, {3'h0, d[4:0]}, "feature written");
			hcs_host_model_i.write(8'h20, 8'hff);
			rd(8'h20, 8'h00);
			hcs_host_model_i.write(HCS_OFS_STATUS_CMD, 8'h02);
			rd(HCS_OFS_STATUS_CMD, 8'h02);
			// Lands in the last reload cycle, so it must be dropped
			hcs_host_model_i.write(HCS_OFS_FEATURE_CFG, 8'h1f);
			settle(6);
			rd(HCS_OFS_STATUS_CMD, 8'h00);
			rd(HCS_OFS_FEATURE_CFG, 8'h00);
			settle(1);
			chk({3'h0, feat}, 8'h00, "feature reloaded");
			hcs_host_model_i.write(HCS_OFS_STATUS_CMD, 8'h00);
			rd(HCS_OFS_STATUS_CMD, 8'h00);
			settle(3);
			chk(8'(exp_q.size()), 8'h00, "reads left unanswered");
			$display("test strap mix %0d done", cfg);
		end
		report_and_stop();
	end
endmodule // hcs_status_command_tb
